// File: verilog/hbe_break_unit.sv
/*
  Hardware break event unit: per-event detectors with address, data and
  direction qualifiers and pass counters, a combiner and a halt request.
  Assumes target bus signals are on i_sys_clk; the trigger pin is async.
*/
`timescale 1ns/1ps
`include "hbe_cfg.svh"

// Overview of operation
// - Halt only after the breakpoint instruction completes
// - No break events while break disabled
// - Fetch event fires on matching prefetch address
// - Data event checks address, data, direction
// - Bit, interrupt and trigger event types
// - Eight address conditions, single or range
// - Eight data conditions, single or range
// - Direction: read, write, or either
// - AND: all enabled events seen, any order
// - Same-time AND: all in one cycle
// - OR: any enabled event breaks
// - State mode: sequencer reaches break state
// - Pass count 1..255 before event satisfied
// - Same-time AND forces pass count one
// - Bus-cycle match only while valid-cycle indicator low; trigger and interrupt completion ungated
module hbe_break_unit #(
  parameter int AW = 20,
  parameter int DW = 16,
  parameter int NEV = 4,
  parameter int NCOND = 8
) (
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // Wishbone classic slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Target bus cycle
  input wire logic i_valid_cycle_n,
  input wire logic [2:0] i_bus_kind,
  input wire logic [AW-1:0] i_tgt_addr,
  input wire logic [DW-1:0] i_tgt_data,
  input wire logic i_tgt_we,
  input wire logic i_int_done,
  input wire logic i_insn_done,
  input wire logic i_run_start,
  input wire logic i_external_trigger_in,
  // Break and interrupt
  output logic o_halt_req,
  output logic o_irq
);

  // ==========================================================
  // Helpers
  // Inclusive range compare; single value when lo equals hi
  function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // Byte-lane merge of a write into a register word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = sel[b] ? dat[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // ==========================================================
  // Register state
  logic en; // Break function enable
  logic [1:0] mode_bits; // Combiner mode field
  logic [31:0] evcfg [NEV]; // Type, direction, pass count
  logic [15:0] evsel [NEV]; // Address mask [7:0], data mask [15:8]
  logic [7:0] seqw [4]; // Sequencer: event mask [3:0], next state [5:4]
  logic [31:0] alo [NCOND], ahi [NCOND]; // Address conditions
  logic [31:0] dlo [NCOND], dhi [NCOND]; // Data conditions
  logic [1:0] brk_state; // Sequencer break state
  logic [1:0] irq_stat, irq_en; // Sticky events and their enables
  logic [31:0] next_evcfg [NEV];
  logic [15:0] next_evsel [NEV];
  logic [7:0] next_seqw [4];
  logic [31:0] next_alo [NCOND], next_ahi [NCOND], next_dlo [NCOND], next_dhi [NCOND];
  logic next_en, next_ack;
  logic [1:0] next_mode, next_brk, next_irq_stat, next_irq_en;
  logic [31:0] next_rdata;
  logic wr, arm, halt_rise, any_fire;
  hbe_pkg::hbe_mode_t mode;
  // Break state is declared here because the status read mux shows it
  logic armed, pending, next_armed, next_pending, next_halt, hit;
  logic [1:0] seq, next_seq; // Sequencer state
  logic [3:0] seq_step; // Events that advance the current state
  logic [NEV-1:0] sat, next_sat; // Events that reached their pass count

  assign mode = hbe_pkg::hbe_mode_t'(mode_bits);
  // Write lands on the edge where the master samples ack
  assign wr = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;
  assign arm = wr & (i_wb_adr == `HBE_OFF_CTRL) & i_wb_sel[0] & i_wb_dat[`HBE_CTRL_ARM];
  assign o_irq = |(irq_stat & irq_en);

  // ==========================================================
  // Bus decode, register writes, read mux, interrupt flags
  always_comb begin
    next_en = en;
    next_mode = mode_bits;
    next_brk = brk_state;
    next_irq_en = irq_en;
    next_evcfg = evcfg;
    next_evsel = evsel;
    next_seqw = seqw;
    next_alo = alo;
    next_ahi = ahi;
    next_dlo = dlo;
    next_dhi = dhi;
    next_ack = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    next_rdata = 32'h0000_0000;
    // Set wins over a clear landing in the same cycle
    next_irq_stat = irq_stat;
    if (wr && i_wb_adr == `HBE_OFF_IRQ_CLR && i_wb_sel[0]) begin
      next_irq_stat = irq_stat & ~i_wb_dat[1:0];
    end
    if (halt_rise) begin
      next_irq_stat[`HBE_IRQ_BREAK] = 1'b1;
    end
    if (any_fire) begin
      next_irq_stat[`HBE_IRQ_EVENT] = 1'b1;
    end
    if (wr) begin
      unique case (i_wb_adr)
        `HBE_OFF_CTRL: begin
          if (i_wb_sel[0]) begin
            next_en = i_wb_dat[`HBE_CTRL_EN];
            next_mode = i_wb_dat[`HBE_CTRL_MODE +: 2];
          end
        end
        `HBE_OFF_IRQ_EN: next_irq_en = i_wb_sel[0] ? i_wb_dat[1:0] : irq_en;
        `HBE_OFF_BRK_STATE: next_brk = i_wb_sel[0] ? i_wb_dat[1:0] : brk_state;
        default: begin
          for (int s = 0; s < 4; s++) begin
            if (i_wb_adr == `HBE_BASE_SEQ + 8'(4 * s) && i_wb_sel[0]) begin
              next_seqw[s] = i_wb_dat[7:0];
            end
          end
          for (int e = 0; e < NEV; e++) begin
            if (i_wb_adr == `HBE_BASE_EVT + 8'(8 * e)) begin
              next_evcfg[e] = merge(evcfg[e], i_wb_dat, i_wb_sel);
            end
            if (i_wb_adr == `HBE_BASE_EVT + 8'(8 * e + 4)) begin
              next_evsel[e] = 16'(merge({16'h0000, evsel[e]}, i_wb_dat, i_wb_sel));
            end
          end
          for (int c = 0; c < NCOND; c++) begin
            if (i_wb_adr == `HBE_BASE_ACOND + 8'(8 * c)) next_alo[c] = merge(alo[c], i_wb_dat, i_wb_sel);
            if (i_wb_adr == `HBE_BASE_ACOND + 8'(8 * c + 4)) next_ahi[c] = merge(ahi[c], i_wb_dat, i_wb_sel);
            if (i_wb_adr == `HBE_BASE_DCOND + 8'(8 * c)) next_dlo[c] = merge(dlo[c], i_wb_dat, i_wb_sel);
            if (i_wb_adr == `HBE_BASE_DCOND + 8'(8 * c + 4)) next_dhi[c] = merge(dhi[c], i_wb_dat, i_wb_sel);
          end
        end
      endcase
    end
    // Read mux; unmapped and write-only words read as zero
    unique case (i_wb_adr)
      `HBE_OFF_CTRL: next_rdata = {28'h0000000, mode_bits, 1'b0, en};
      `HBE_OFF_STAT: next_rdata = {23'h000000, 4'(sat), 2'(seq), armed, pending, o_halt_req};
      `HBE_OFF_IRQ_STAT: next_rdata = {30'h00000000, irq_stat};
      `HBE_OFF_IRQ_EN: next_rdata = {30'h00000000, irq_en};
      `HBE_OFF_BRK_STATE: next_rdata = {30'h00000000, brk_state};
      default: begin
        for (int s = 0; s < 4; s++) begin
          if (i_wb_adr == `HBE_BASE_SEQ + 8'(4 * s)) next_rdata = {24'h000000, seqw[s]};
        end
        for (int e = 0; e < NEV; e++) begin
          if (i_wb_adr == `HBE_BASE_EVT + 8'(8 * e)) next_rdata = evcfg[e];
          if (i_wb_adr == `HBE_BASE_EVT + 8'(8 * e + 4)) next_rdata = {16'h0000, evsel[e]};
        end
        for (int c = 0; c < NCOND; c++) begin
          if (i_wb_adr == `HBE_BASE_ACOND + 8'(8 * c)) next_rdata = alo[c];
          if (i_wb_adr == `HBE_BASE_ACOND + 8'(8 * c + 4)) next_rdata = ahi[c];
          if (i_wb_adr == `HBE_BASE_DCOND + 8'(8 * c)) next_rdata = dlo[c];
          if (i_wb_adr == `HBE_BASE_DCOND + 8'(8 * c + 4)) next_rdata = dhi[c];
        end
      end
    endcase
  end

  // Register group flops
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      en <= 1'b0;
      mode_bits <= 2'h0;
      brk_state <= 2'h0;
      irq_stat <= 2'h0;
      irq_en <= 2'h0;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
      for (int e = 0; e < NEV; e++) begin
        evcfg[e] <= {16'h0000, `HBE_PASS_RST, 8'h00};
        evsel[e] <= 16'h0000;
      end
      for (int s = 0; s < 4; s++) seqw[s] <= 8'h00;
      for (int c = 0; c < NCOND; c++) begin
        alo[c] <= 32'h0000_0000;
        ahi[c] <= 32'h0000_0000;
        dlo[c] <= 32'h0000_0000;
        dhi[c] <= 32'h0000_0000;
      end
    end else if (i_clk_en) begin
      en <= next_en;
      mode_bits <= next_mode;
      brk_state <= next_brk;
      irq_stat <= next_irq_stat;
      irq_en <= next_irq_en;
      o_wb_ack <= next_ack;
      o_wb_dat <= next_rdata;
      evcfg <= next_evcfg;
      evsel <= next_evsel;
      seqw <= next_seqw;
      alo <= next_alo;
      ahi <= next_ahi;
      dlo <= next_dlo;
      dhi <= next_dhi;
    end
  end

  // ==========================================================
  // Trigger pin synchroniser; the second and third stages feed the edge detector
  logic trig_s1, trig_s2, trig_s3, trig_rise;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      {trig_s1, trig_s2, trig_s3} <= 3'h0;
    end else if (i_clk_en) begin
      {trig_s1, trig_s2, trig_s3} <= {i_external_trigger_in, trig_s1, trig_s2};
    end
  end
  assign trig_rise = trig_s2 & ~trig_s3;

  // ==========================================================
  // Condition comparators and per-event detectors
  logic valid; // Address, data and bus status meaningful
  logic [NCOND-1:0] ahit, dhit;
  logic [NEV-1:0] evon, match, fire;
  logic [7:0] cnt [NEV], next_cnt [NEV];
  assign valid = ~i_valid_cycle_n;

  genvar gc, ge;
  generate
    for (gc = 0; gc < NCOND; gc++) begin : g_cond
      assign ahit[gc] = in_range(32'(i_tgt_addr), alo[gc], ahi[gc]);
      assign dhit[gc] = in_range(32'(i_tgt_data), dlo[gc], dhi[gc]);
    end
    for (ge = 0; ge < NEV; ge++) begin : g_evt
      hbe_pkg::hbe_evtype_t ty;
      logic amatch, dmatch, dir_ok;
      assign ty = hbe_pkg::hbe_evtype_t'(evcfg[ge][2:0]);
      assign evon[ge] = (ty != hbe_pkg::HBE_EV_OFF);
      assign amatch = |(evsel[ge][7:0] & ahit);
      // No data conditions selected means any data value
      assign dmatch = ~|evsel[ge][15:8] | |(evsel[ge][15:8] & dhit);
      assign dir_ok = i_tgt_we ? evcfg[ge][`HBE_EVT_DIR + `HBE_DIR_WR]
                               : evcfg[ge][`HBE_EVT_DIR + `HBE_DIR_RD];
      always_comb begin
        unique case (ty)
          hbe_pkg::HBE_EV_FETCH: match[ge] = valid & (i_bus_kind == `HBE_KIND_FETCH) & amatch;
          hbe_pkg::HBE_EV_DATA: match[ge] = valid & (i_bus_kind == `HBE_KIND_DATA) & amatch
                                            & dmatch & dir_ok;
          hbe_pkg::HBE_EV_BIT: match[ge] = valid & (i_bus_kind == `HBE_KIND_BIT) & amatch & dir_ok;
          // Direction bits reused: bit 3 occurrence, bit 4 completion
          hbe_pkg::HBE_EV_INTR: match[ge] = (evcfg[ge][`HBE_EVT_DIR] & valid
                                             & (i_bus_kind == `HBE_KIND_INTACK))
                                            | (evcfg[ge][`HBE_EVT_DIR + 1] & i_int_done);
          hbe_pkg::HBE_EV_TRIG: match[ge] = trig_rise;
          default: match[ge] = 1'b0;
        endcase
      end
      // Final pass of the count; a zero count behaves as one
      assign fire[ge] = en & armed & match[ge] & ~sat[ge] & (cnt[ge] <= 8'h01);
    end
  endgenerate
  assign any_fire = |fire;

  // ==========================================================
  // Pass counters, sequencer and halt request

  always_comb begin
    next_cnt = cnt;
    next_sat = sat;
    next_seq = seq;
    next_armed = armed;
    next_pending = pending;
    next_halt = o_halt_req;
    seq_step = seqw[seq][3:0];
    if (arm || i_run_start) begin
      // Reload counters and restart the sequence
      for (int e = 0; e < NEV; e++) next_cnt[e] = evcfg[e][`HBE_EVT_PASS +: 8];
      next_sat = '0;
      next_seq = 2'h0;
    end else begin
      for (int e = 0; e < NEV; e++) begin
        if (en && armed && match[e] && !sat[e] && cnt[e] > 8'h01) begin
          next_cnt[e] = cnt[e] - 8'h01;
        end else if (fire[e] && mode == hbe_pkg::HBE_STATE) begin
          next_cnt[e] = evcfg[e][`HBE_EVT_PASS +: 8];
        end else if (fire[e]) begin
          next_sat[e] = 1'b1;
        end
      end
      if (mode == hbe_pkg::HBE_STATE && |(seq_step[NEV-1:0] & fire)) begin
        next_seq = seqw[seq][5:4];
      end
    end
    unique case (mode)
      hbe_pkg::HBE_AND: hit = |evon & &(sat | ~evon);
      hbe_pkg::HBE_SAME: hit = |evon & &(match | ~evon);
      hbe_pkg::HBE_OR: hit = |(sat & evon);
      hbe_pkg::HBE_STATE: hit = (next_seq != seq) & (next_seq == brk_state);
    endcase
    hit = hit & en & armed & ~arm;
    if (hit) begin
      next_pending = 1'b1;
      next_armed = 1'b0;
    end
    // Wait for the breakpoint instruction to finish
    if (pending && i_insn_done && en) begin
      next_halt = 1'b1;
      next_pending = 1'b0;
    end
    if (!en) begin
      next_pending = 1'b0;
    end
    if (arm) begin
      next_halt = 1'b0;
      next_pending = 1'b0;
      next_armed = 1'b1;
    end
  end
  assign halt_rise = next_halt & ~o_halt_req;

  // Break group flops
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int e = 0; e < NEV; e++) cnt[e] <= `HBE_PASS_RST;
      sat <= '0;
      seq <= 2'h0;
      armed <= 1'b0;
      pending <= 1'b0;
      o_halt_req <= 1'b0;
    end else if (i_clk_en) begin
      cnt <= next_cnt;
      sat <= next_sat;
      seq <= next_seq;
      armed <= next_armed;
      pending <= next_pending;
      o_halt_req <= next_halt;
    end
  end

  // ==========================================================
  // Checks
  sequence s_pend_done;
    pending && i_insn_done && en && !arm && i_clk_en;
  endsequence
  sequence s_halt_set;
    o_halt_req;
  endsequence
  chk_halt_after_done: assert property (s_pend_done |=> s_halt_set)
    else $error("halt not raised after instruction completion");
  chk_halt_needs_en: assert property ($rose(o_halt_req) |-> $past(en) && $past(pending))
    else $error("halt raised without enable or pending break");
  chk_fetch_kind: assert property (match[0] && evcfg[0][2:0] == 3'(hbe_pkg::HBE_EV_FETCH)
                                   |-> valid && i_bus_kind == `HBE_KIND_FETCH)
    else $error("fetch event fired on non-fetch cycle");
  chk_data_read_only: assert property (match[0] && evcfg[0][2:0] == 3'(hbe_pkg::HBE_EV_DATA)
                                       && evcfg[0][4:3] == 2'h1 |-> !i_tgt_we)
    else $error("read-only data event fired on a write");
  chk_invalid_cycle: assert property (i_valid_cycle_n && !i_int_done && !trig_rise |-> match == '0)
    else $error("event matched outside a valid bus cycle");
  chk_or_break: assert property (i_clk_en && mode == hbe_pkg::HBE_OR && en && armed && !arm
                                 && |(sat & evon) |=> pending || o_halt_req)
    else $error("OR mode failed to break");
  chk_same_break: assert property (i_clk_en && mode == hbe_pkg::HBE_SAME && en && armed && !arm
                                   && |evon && &(match | ~evon) |=> pending)
    else $error("same-time AND failed to break");
  chk_sat_cause: assert property ($rose(sat[0]) |-> $past(match[0]) && $past(en))
    else $error("event satisfied without a match");
  chk_halt_hold: assert property (o_halt_req && !arm |=> o_halt_req)
    else $error("halt dropped before re-arm");
  chk_ack_pulse: assert property (o_wb_ack && i_clk_en |=> !o_wb_ack)
    else $error("ack held two cycles");

endmodule

// File: verilog/hbe_cfg.svh
/*
  Register map, field positions, reset values and bus codes of the hardware
  break event unit. Assumes inclusion by bare name from the design files.
*/
`ifndef HBE_CFG_SVH
`define HBE_CFG_SVH

// ==========================================================
// Register byte offsets (Wishbone, one word per register)
`define HBE_OFF_CTRL 8'h00
`define HBE_OFF_STAT 8'h04
`define HBE_OFF_IRQ_STAT 8'h08
`define HBE_OFF_IRQ_CLR 8'h0C
`define HBE_OFF_IRQ_EN 8'h10
`define HBE_OFF_BRK_STATE 8'h14
`define HBE_BASE_SEQ 8'h20
`define HBE_BASE_EVT 8'h40
`define HBE_BASE_ACOND 8'h80
`define HBE_BASE_DCOND 8'hC0

// ==========================================================
// Control fields
`define HBE_CTRL_EN 0
`define HBE_CTRL_ARM 1
`define HBE_CTRL_MODE 2
`define HBE_CTRL_RST 3'h0

// ==========================================================
// Event config fields: type [2:0], direction [4:3], pass [15:8]
`define HBE_EVT_DIR 3
`define HBE_EVT_PASS 8
`define HBE_PASS_RST 8'h01
`define HBE_DIR_RD 0
`define HBE_DIR_WR 1

// ==========================================================
// Target bus-unit status codes on i_bus_kind
`define HBE_KIND_FETCH 3'h1
`define HBE_KIND_DATA 3'h2
`define HBE_KIND_BIT 3'h3
`define HBE_KIND_INTACK 3'h4

// ==========================================================
// Interrupt status bits
`define HBE_IRQ_BREAK 0
`define HBE_IRQ_EVENT 1

`endif

// File: verilog/hbe_pkg.sv
/*
  Types of the hardware break event unit: combiner modes and event types.
  Assumes register fields carry these values in declaration order.
*/
package hbe_pkg;
  // Combiner mode, field CTRL[3:2]
  typedef enum logic [1:0] {HBE_AND, HBE_SAME, HBE_OR, HBE_STATE} hbe_mode_t;
  // Event type, field EVT_CFG[2:0]
  typedef enum logic [2:0] {HBE_EV_OFF, HBE_EV_FETCH, HBE_EV_DATA, HBE_EV_BIT, HBE_EV_INTR,
                            HBE_EV_TRIG} hbe_evtype_t;
endpackage

// File: tb/hbe_tgt_model.sv
/*
  Target processor model: issues bus cycles, status pulses and the trigger pin.
  Assumes the bench calls its tasks from outside, one at a time.
*/
`timescale 1ns/1ps
module hbe_tgt_model #(
  parameter int AW = 20,
  parameter int DW = 16
) (
  // Clock
  input wire logic i_sys_clk,
  // Target bus cycle
  output logic o_valid_cycle_n,
  output logic [2:0] o_bus_kind,
  output logic [AW-1:0] o_tgt_addr,
  output logic [DW-1:0] o_tgt_data,
  output logic o_tgt_we,
  // Status pulses and trigger pin
  output logic o_int_done,
  output logic o_insn_done,
  output logic o_run_start,
  output logic o_external_trigger_in
);
  // ==========================================================
  // Request latch, filled on the falling edge so it never races the rising one
  logic req = 1'h0;
  logic req_v, req_w;
  logic [2:0] req_k, req_p;
  logic [AW-1:0] req_a;
  logic [DW-1:0] req_d;
  initial begin
    {o_valid_cycle_n, o_bus_kind, o_tgt_we, o_int_done, o_insn_done, o_run_start} = 8'h80;
    o_tgt_addr = '0;
    o_tgt_data = '0;
    o_external_trigger_in = 1'h0;
  end
  // Bus outputs change only just after a rising edge
  always @(posedge i_sys_clk) begin
    if (req) begin
      // Requested cycle, valid or deliberately invalid with live address
      o_valid_cycle_n <= ~req_v;
      o_bus_kind <= req_k;
      o_tgt_addr <= req_a;
      o_tgt_data <= req_d;
      o_tgt_we <= req_w;
      {o_run_start, o_int_done, o_insn_done} <= req_p;
      req <= 1'h0;
    end else begin
      // Released bus shows inverted values, so stale matches are not hidden
      o_valid_cycle_n <= 1'h1;
      o_bus_kind <= 3'h0;
      o_tgt_addr <= ~o_tgt_addr;
      o_tgt_data <= ~o_tgt_data;
      o_tgt_we <= ~o_tgt_we;
      {o_run_start, o_int_done, o_insn_done} <= 3'h0;
    end
  end
  // One cycle on the bus; p holds {run start, interrupt done, insn done}
  task automatic put(input logic v, input logic [2:0] k, input logic [AW-1:0] a, input logic [DW-1:0] d,
                     input logic w, input logic [2:0] p);
    @(negedge i_sys_clk);
    {req_v, req_k, req_a, req_d, req_w, req_p} = {v, k, a, d, w, p};
    req = 1'h1;
    @(posedge i_sys_clk);
  endtask
  // Trigger pin level, asynchronous to the unit by nature
  task automatic trig(input logic lvl);
    @(posedge i_sys_clk);
    o_external_trigger_in <= lvl;
  endtask
endmodule

// File: tb/hbe_break_unit_tb.sv
/*
  Self-checking bench of the hardware break event unit.
  Assumes the unit's package and header are compiled first; one 25 MHz clock.
*/
`timescale 1ns/1ps
`include "hbe_cfg.svh"
module hbe_break_unit_tb;
  // ==========================================================
  // Clock, reset, bus master, target nets and counters
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, vld_n, twe, intd, insn, run, trg, halt, irq;
  logic [2:0] kind;
  logic [19:0] taddr;
  logic [15:0] tdata;
  int err_count = 0;
  int checks = 0;
  always #20 sys_clk = ~sys_clk;
  // Clock enable and byte lanes held on: every register access is a full word
  hbe_break_unit u_dut (.i_sys_clk(sys_clk), .i_rst(rst), .i_clk_en(1'h1), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hF), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_valid_cycle_n(vld_n), .i_bus_kind(kind), .i_tgt_addr(taddr), .i_tgt_data(tdata), .i_tgt_we(twe),
    .i_int_done(intd), .i_insn_done(insn), .i_run_start(run), .i_external_trigger_in(trg),
    .o_halt_req(halt), .o_irq(irq));
  hbe_tgt_model u_tgt (.i_sys_clk(sys_clk), .o_valid_cycle_n(vld_n), .o_bus_kind(kind), .o_tgt_addr(taddr),
    .o_tgt_data(tdata), .o_tgt_we(twe), .o_int_done(intd), .o_insn_done(insn), .o_run_start(run),
    .o_external_trigger_in(trg));
  // ==========================================================
  // Shared tasks
  task automatic end_sim;
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then release for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    q = rdat;
    {cyc, stb} <= 2'h0;
    if (n >= 20) err_count++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'h0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic setev(input int e, input logic [31:0] cfg, input logic [31:0] msk);
    wr(8'(`HBE_BASE_EVT + 8 * e), cfg);
    wr(8'(`HBE_BASE_EVT + 8 * e + 4), msk);
  endtask
  task automatic cond(input logic [7:0] base, input int c, input logic [31:0] lo, input logic [31:0] hi);
    wr(8'(base + 8 * c), lo);
    wr(8'(base + 8 * c + 4), hi);
  endtask
  task automatic arm(input hbe_pkg::hbe_mode_t m, input logic en);
    wr(`HBE_OFF_CTRL, {28'h0, m, 1'h1, en});
  endtask
  // All events off, then a run start to clear what is left over
  task automatic clr;
    for (int e = 0; e < 4; e++) setev(e, 32'h100, 32'h0);
    u_tgt.put(1'h0, 3'h0, 20'h0, 16'h0, 1'h0, 3'h4);
  endtask
  task automatic hit(input logic [2:0] k, input logic [19:0] a, input logic [15:0] d, input logic w);
    u_tgt.put(1'h1, k, a, d, w, 3'h0);
  endtask
  // Let the match settle, complete the instruction, then judge the halt
  task automatic done(input logic exp);
    repeat (3) @(posedge sys_clk);
    u_tgt.put(1'h0, 3'h0, 20'h0, 16'h0, 1'h0, 3'h1);
    repeat (2) @(posedge sys_clk);
    chk(halt, exp);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rd(`HBE_OFF_CTRL, 32'h0);
    rd(8'h48, 32'h100);
    rd(8'hFC, 32'h0);
    wr(`HBE_OFF_STAT, 32'hFFFFFFFF);
    rd(`HBE_OFF_STAT, 32'h0);
  endtask
  task automatic t_or_fetch;
    clr;
    cond(`HBE_BASE_ACOND, 0, 32'h1234, 32'h1234);
    cond(`HBE_BASE_ACOND, 7, 32'h2000, 32'h2003);
    setev(0, 32'h101, 32'h81);
    wr(`HBE_OFF_IRQ_EN, 32'h1);
    arm(hbe_pkg::HBE_OR, 1'h1);
    hit(`HBE_KIND_FETCH, 20'h01235, 16'h0, 1'h0);
    done(1'h0);
    hit(`HBE_KIND_DATA, 20'h01234, 16'h0, 1'h0);
    done(1'h0);
    hit(`HBE_KIND_FETCH, 20'h02003, 16'h0, 1'h0);
    repeat (6) @(posedge sys_clk);
    chk(halt, 1'h0);
    done(1'h1);
    chk(irq, 1'h1);
    rd(`HBE_OFF_IRQ_STAT, 32'h3);
    repeat (4) @(posedge sys_clk);
    chk(halt, 1'h1);
    wr(`HBE_OFF_IRQ_EN, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'h0);
    wr(`HBE_OFF_IRQ_CLR, 32'h3);
    wr(`HBE_OFF_IRQ_EN, 32'h1);
    rd(`HBE_OFF_IRQ_STAT, 32'h0);
    arm(hbe_pkg::HBE_OR, 1'h1);
    repeat (2) @(posedge sys_clk);
    chk(halt, 1'h0);
  endtask
  task automatic t_disabled;
    clr;
    setev(0, 32'h101, 32'h1);
    arm(hbe_pkg::HBE_OR, 1'h0);
    hit(`HBE_KIND_FETCH, 20'h01234, 16'h0, 1'h0);
    done(1'h0);
  endtask
  task automatic t_data;
    clr;
    cond(`HBE_BASE_ACOND, 1, 32'h100, 32'h1FF);
    cond(`HBE_BASE_DCOND, 2, 32'h40, 32'h50);
    setev(0, 32'h112, 32'h402);
    arm(hbe_pkg::HBE_OR, 1'h1);
    u_tgt.put(1'h0, `HBE_KIND_DATA, 20'h00180, 16'h0045, 1'h1, 3'h0);
    done(1'h0);
    hit(`HBE_KIND_DATA, 20'h00180, 16'h0045, 1'h0);
    done(1'h0);
    hit(`HBE_KIND_DATA, 20'h00180, 16'h0051, 1'h1);
    done(1'h0);
    hit(`HBE_KIND_DATA, 20'h001FF, 16'h0040, 1'h1);
    done(1'h1);
    setev(0, 32'h11A, 32'h402);
    arm(hbe_pkg::HBE_OR, 1'h1);
    hit(`HBE_KIND_DATA, 20'h00100, 16'h0050, 1'h0);
    done(1'h1);
    setev(0, 32'h10A, 32'h402);
    arm(hbe_pkg::HBE_OR, 1'h1);
    hit(`HBE_KIND_DATA, 20'h00100, 16'h0050, 1'h1);
    done(1'h0);
    hit(`HBE_KIND_DATA, 20'h00100, 16'h0050, 1'h0);
    done(1'h1);
  endtask
  task automatic t_pass;
    clr;
    setev(0, 32'h301, 32'h1);
    arm(hbe_pkg::HBE_OR, 1'h1);
    for (int i = 0; i < 3; i++) begin
      hit(`HBE_KIND_FETCH, 20'h01234, 16'h0, 1'h0);
      done(i == 2);
    end
    arm(hbe_pkg::HBE_OR, 1'h1);
    hit(`HBE_KIND_FETCH, 20'h01234, 16'h0, 1'h0);
    done(1'h0);
    // Run start reloads the count again: two more hits must not break
    u_tgt.put(1'h0, 3'h0, 20'h0, 16'h0, 1'h0, 3'h4);
    for (int i = 0; i < 2; i++) begin
      hit(`HBE_KIND_FETCH, 20'h01234, 16'h0, 1'h0);
      done(1'h0);
    end
  endtask
  task automatic t_and;
    clr;
    setev(0, 32'h101, 32'h1);
    setev(1, 32'h101, 32'h80);
    arm(hbe_pkg::HBE_AND, 1'h1);
    hit(`HBE_KIND_FETCH, 20'h02001, 16'h0, 1'h0);
    done(1'h0);
    hit(`HBE_KIND_FETCH, 20'h01234, 16'h0, 1'h0);
    done(1'h1);
  endtask
  task automatic t_same;
    clr;
    cond(`HBE_BASE_ACOND, 1, 32'h1234, 32'h1237);
    cond(`HBE_BASE_ACOND, 2, 32'h3000, 32'h3000);
    setev(0, 32'h501, 32'h5);
    setev(1, 32'h101, 32'h2);
    arm(hbe_pkg::HBE_SAME, 1'h1);
    hit(`HBE_KIND_FETCH, 20'h01235, 16'h0, 1'h0);
    done(1'h0);
    hit(`HBE_KIND_FETCH, 20'h03000, 16'h0, 1'h0);
    done(1'h0);
    hit(`HBE_KIND_FETCH, 20'h01234, 16'h0, 1'h0);
    done(1'h1);
  endtask
  task automatic t_state;
    clr;
    setev(0, 32'h101, 32'h1);
    setev(1, 32'h101, 32'h80);
    wr(8'(`HBE_BASE_SEQ), 32'h12);
    wr(8'(`HBE_BASE_SEQ + 4), 32'h21);
    wr(`HBE_OFF_BRK_STATE, 32'h2);
    arm(hbe_pkg::HBE_STATE, 1'h1);
    hit(`HBE_KIND_FETCH, 20'h01234, 16'h0, 1'h0);
    done(1'h0);
    hit(`HBE_KIND_FETCH, 20'h02000, 16'h0, 1'h0);
    done(1'h0);
    hit(`HBE_KIND_FETCH, 20'h01234, 16'h0, 1'h0);
    done(1'h1);
  endtask
  task automatic t_types;
    clr;
    setev(0, 32'h11B, 32'h1);
    arm(hbe_pkg::HBE_OR, 1'h1);
    hit(`HBE_KIND_BIT, 20'h01234, 16'h0, 1'h0);
    done(1'h1);
    setev(0, 32'h10C, 32'h1);
    arm(hbe_pkg::HBE_OR, 1'h1);
    hit(`HBE_KIND_INTACK, 20'h01234, 16'h0, 1'h0);
    done(1'h1);
    setev(0, 32'h114, 32'h1);
    arm(hbe_pkg::HBE_OR, 1'h1);
    u_tgt.put(1'h0, 3'h0, 20'h0, 16'h0, 1'h0, 3'h2);
    done(1'h1);
    setev(0, 32'h105, 32'h0);
    arm(hbe_pkg::HBE_OR, 1'h1);
    u_tgt.trig(1'h1);
    repeat (4) @(posedge sys_clk);
    done(1'h1);
    u_tgt.trig(1'h0);
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'h0;
    t_regs;
    t_or_fetch;
    t_disabled;
    t_data;
    t_pass;
    t_and;
    t_same;
    t_state;
    t_types;
    end_sim;
  end
  // Whole run needs about 700 cycles; more than ten times that means a hang
  initial begin
    repeat (8000) @(posedge sys_clk);
    err_count++;
    end_sim;
  end
endmodule
